// ==== rtl/rsc_pkg.sv ====
// package with constants of the relay setpoint controller
package rsc_pkg;
    // relay count
    localparam int RELAYS = 6;
    // width of process values, signed
    localparam int VAL_W = 16;
    // relay function codes
    localparam logic [3:0] FN_OFF = 4'h0;
    localparam logic [3:0] FN_LEVEL = 4'h1;
    localparam logic [3:0] FN_INBND = 4'h2;
    localparam logic [3:0] FN_OUTBND = 4'h3;
    localparam logic [3:0] FN_RATE = 4'h4;
    localparam logic [3:0] FN_TEMP = 4'h5;
    localparam logic [3:0] FN_ECHO = 4'h6;
    localparam logic [3:0] FN_CABLE = 4'h7;
    localparam logic [3:0] FN_PUMP = 4'h8;
    localparam logic [3:0] FN_PULSE = 4'h9;
    // value source codes
    localparam logic [1:0] SRC_P1 = 2'h0;
    localparam logic [1:0] SRC_P2 = 2'h1;
    localparam logic [1:0] SRC_P3 = 2'h2;
    // fail-safe modes
    localparam logic [1:0] FS_HOLD = 2'h0;
    localparam logic [1:0] FS_HIGH = 2'h1;
    localparam logic [1:0] FS_LOW = 2'h2;
    // register map, one word per relay block of four plus globals
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FSLEVEL = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_TIMER = 8'h0c;
    localparam logic [7:0] REG_RELAY_BASE = 8'h10;
    localparam logic [7:0] REG_RELAY_STRIDE = 8'h10;
    // per relay offsets inside its block
    localparam logic [3:0] RO_CFG = 4'h0;
    localparam logic [3:0] RO_ON = 4'h4;
    localparam logic [3:0] RO_OFF = 4'h8;
    // cfg field positions
    localparam int CFG_FN_LSB = 0;
    localparam int CFG_SRC_LSB = 4;
    localparam int CFG_INV_BIT = 6;
    // ctrl field positions
    localparam int CTRL_FS_LSB = 0;
    localparam int CTRL_DUAL_BIT = 2;
    localparam int CTRL_AVG_BIT = 3;
    localparam int CTRL_NAV_BIT = 4;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] TIMER_RST = 32'h0000_0064;
    // timing
    localparam int CLK_HZ = 50_000_000;
    localparam int PULSE_MS = 200;
    localparam int PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
    // hysteresis of bounds alarms, percent of span
    localparam int BAND_PCT = 2;
endpackage : rsc_pkg

// ==== rtl/rsc_relay_ctrl.sv ====
// six-relay setpoint controller with fail-safe and navigation override
`timescale 1ns/1ns

module rsc_relay_ctrl
    import rsc_pkg::*;
#(
    parameter int N = RELAYS,
    parameter int W = VAL_W,
    parameter int PULSE_CYCLES = PULSE_CYC
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // measurement front end
    input wire logic measUpdate,
    input wire logic signed [15:0] level1,
    input wire logic signed [15:0] level2,
    input wire logic signed [15:0] rate,
    input wire logic signed [15:0] temperature,
    input wire logic signed [15:0] span,
    input wire logic measError,
    input wire logic echoValid,
    input wire logic cableFault,
    input wire logic eventPulse,
    // relay outputs
    output logic [5:0] relayCoil,
    output logic [5:0] relayIcon
);

    // per relay configuration
    logic [6:0] cfg_q [N];
    logic signed [W-1:0] onSp_q [N];
    logic signed [W-1:0] offSp_q [N];
    // global control, fail-safe level and timer length in updates
    logic [31:0] ctrl_q;
    logic signed [W-1:0] fsLevel_q;
    logic [31:0] timerLen_q;
    // fail-safe timer state
    logic [31:0] fsCnt_q;
    logic expired_q;
    // logical relay states, icon sense
    logic [N-1:0] act_q;
    logic [N-1:0] act_d;
    // one-shot pulse counters
    logic [31:0] pulseCnt_q [N];
    // first update seen
    logic started_q;
    logic navPrev_q;

    wire navView = ctrl_q[CTRL_NAV_BIT];
    wire navEntry = navView && !navPrev_q;

    // hysteresis comparator: high sense when on above off
    function automatic logic hyst(input logic prev, input logic signed [W-1:0] v,
            input logic signed [W-1:0] onV, input logic signed [W-1:0] offV);
        if (onV > offV) begin
            hyst = prev ? (v > offV) : (v >= onV);
        end else begin
            hyst = prev ? (v < offV) : (v <= onV);
        end
    endfunction : hyst

    // point three and level selection
    logic signed [W:0] sum3;
    logic signed [W-1:0] point3;
    logic signed [W-1:0] useL1;
    logic signed [W-1:0] useL2;
    always_comb begin
        useL1 = expired_q && measError ? fsLevel_q : level1;
        useL2 = expired_q && measError ? fsLevel_q : level2;
        if (ctrl_q[CTRL_AVG_BIT]) begin
            sum3 = {useL1[W-1], useL1} + {useL2[W-1], useL2};
            point3 = sum3[W:1];
        end else begin
            sum3 = {useL1[W-1], useL1} - {useL2[W-1], useL2};
            point3 = sum3[W-1:0];
        end
    end

    // band of two percent span
    logic signed [W+7:0] bandWide;
    logic signed [W-1:0] band;
    always_comb begin
        bandWide = (W+8)'(span) * (W+8)'(BAND_PCT) / (W+8)'(100);
        band = bandWide[W-1:0];
    end

    // next relay state per function
    always_comb begin
        for (int i = 0; i < N; i++) begin
            logic signed [W-1:0] lv;
            logic signed [W-1:0] lo;
            logic signed [W-1:0] hi;
            logic inZone;
            lv = level1;
            lo = '0;
            hi = '0;
            inZone = 1'b0;
            case (cfg_q[i][CFG_SRC_LSB +: 2])
                SRC_P2: lv = useL2;
                SRC_P3: lv = ctrl_q[CTRL_DUAL_BIT] ? point3 : useL1;
                default: lv = useL1;
            endcase
            lo = onSp_q[i] < offSp_q[i] ? onSp_q[i] : offSp_q[i];
            hi = onSp_q[i] < offSp_q[i] ? offSp_q[i] : onSp_q[i];
            // widen the zone when active so it leaves only past the band
            if (act_q[i]) begin
                inZone = (lv >= lo - band) && (lv <= hi + band);
            end else begin
                inZone = (lv >= lo + band) && (lv <= hi - band);
            end
            act_d[i] = act_q[i];
            case (cfg_q[i][3:0])
                FN_LEVEL: act_d[i] = hyst(act_q[i], lv, onSp_q[i], offSp_q[i]);
                FN_INBND: act_d[i] = inZone;
                FN_OUTBND: begin
                    // out zone uses the inverted band sense
                    if (act_q[i]) begin
                        act_d[i] = !((lv >= lo + band) && (lv <= hi - band));
                    end else begin
                        act_d[i] = !((lv >= lo - band) && (lv <= hi + band));
                    end
                end
                // negative setpoints make emptying fall under the low sense
                FN_RATE: act_d[i] = hyst(act_q[i], rate, onSp_q[i], offSp_q[i]);
                FN_TEMP: act_d[i] = hyst(act_q[i], temperature, onSp_q[i], offSp_q[i]);
                FN_ECHO: act_d[i] = expired_q;
                FN_CABLE: act_d[i] = cableFault;
                FN_PUMP: act_d[i] = hyst(act_q[i], lv, onSp_q[i], offSp_q[i]);
                default: act_d[i] = 1'b0;
            endcase
            // level alarms forced by fail-safe mode while expired
            if (expired_q && (cfg_q[i][3:0] == FN_LEVEL || cfg_q[i][3:0] == FN_INBND
                    || cfg_q[i][3:0] == FN_OUTBND)) begin
                case (ctrl_q[CTRL_FS_LSB +: 2])
                    FS_HIGH: act_d[i] = onSp_q[i] > offSp_q[i];
                    FS_LOW: act_d[i] = onSp_q[i] < offSp_q[i];
                    default: act_d[i] = act_q[i];
                endcase
            end
        end
    end

    // fail-safe timer counts updates while in error
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fsCnt_q <= 32'h0000_0000;
            expired_q <= 1'b0;
        end else if (clkEn && measUpdate) begin
            if (echoValid && !measError) begin
                fsCnt_q <= 32'h0000_0000;
                expired_q <= 1'b0;
            end else if (measError) begin
                if (fsCnt_q >= timerLen_q) begin
                    expired_q <= 1'b1;
                end else begin
                    fsCnt_q <= fsCnt_q + 32'h0000_0001;
                end
            end
        end
    end

    // relay state update, only on strobe; pumps off on navigation entry
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            act_q <= '0;
            started_q <= 1'b0;
            navPrev_q <= 1'b0;
        end else if (clkEn) begin
            navPrev_q <= navView;
            if (measUpdate) begin
                act_q <= act_d;
                started_q <= 1'b1;
            end
            if (navEntry) begin
                for (int i = 0; i < N; i++) begin
                    if (cfg_q[i][3:0] == FN_PUMP) begin
                        act_q[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // pulse timers for totalizer and sampler relays
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                pulseCnt_q[i] <= 32'h0000_0000;
            end
        end else if (clkEn) begin
            for (int i = 0; i < N; i++) begin
                if (cfg_q[i][3:0] != FN_PULSE) begin
                    pulseCnt_q[i] <= 32'h0000_0000;
                end else if (eventPulse && pulseCnt_q[i] == 32'h0000_0000) begin
                    pulseCnt_q[i] <= 32'(PULSE_CYCLES);
                end else if (pulseCnt_q[i] != 32'h0000_0000) begin
                    pulseCnt_q[i] <= pulseCnt_q[i] - 32'h0000_0001;
                end
            end
        end
    end

    // coil drive: alarms de-energize in alarm, controls energize when active
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            relayCoil <= '0;
            relayIcon <= '0;
        end else if (clkEn) begin
            for (int i = 0; i < N; i++) begin
                logic isAlarm;
                logic on;
                isAlarm = cfg_q[i][3:0] inside {FN_LEVEL, FN_INBND, FN_OUTBND, FN_RATE,
                    FN_TEMP, FN_ECHO, FN_CABLE};
                on = cfg_q[i][3:0] == FN_PULSE ? pulseCnt_q[i] != 32'h0000_0000 : act_q[i];
                relayIcon[i] <= on;
                if (!started_q || cfg_q[i][3:0] == FN_OFF) begin
                    relayCoil[i] <= 1'b0;
                end else if (isAlarm) begin
                    relayCoil[i] <= !on ^ cfg_q[i][CFG_INV_BIT];
                end else begin
                    relayCoil[i] <= on ^ cfg_q[i][CFG_INV_BIT];
                end
            end
        end
    end

    // register writes; relay blocks at base plus stride times index
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
            fsLevel_q <= '0;
            timerLen_q <= TIMER_RST;
            for (int i = 0; i < N; i++) begin
                cfg_q[i] <= 7'h00;
                onSp_q[i] <= '0;
                offSp_q[i] <= '0;
            end
        end else if (clkEn && regWr) begin
            if (regAddr == REG_CTRL) begin
                ctrl_q <= regWdata;
            end else if (regAddr == REG_FSLEVEL) begin
                fsLevel_q <= regWdata[W-1:0];
            end else if (regAddr == REG_TIMER) begin
                timerLen_q <= regWdata;
            end else begin
                for (int i = 0; i < N; i++) begin
                    if (regAddr == REG_RELAY_BASE + 8'(i) * REG_RELAY_STRIDE + 8'(RO_CFG)) begin
                        cfg_q[i] <= regWdata[6:0];
                    end else if (regAddr == REG_RELAY_BASE + 8'(i) * REG_RELAY_STRIDE
                            + 8'(RO_ON)) begin
                        onSp_q[i] <= regWdata[W-1:0];
                    end else if (regAddr == REG_RELAY_BASE + 8'(i) * REG_RELAY_STRIDE
                            + 8'(RO_OFF)) begin
                        offSp_q[i] <= regWdata[W-1:0];
                    end
                end
            end
        end
    end

    // register reads, one cycle later; unmapped reads zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regRdata <= 32'h0000_0000;
        end else if (clkEn) begin
            regRdata <= 32'h0000_0000;
            if (regRd) begin
                if (regAddr == REG_CTRL) begin
                    regRdata <= ctrl_q;
                end else if (regAddr == REG_FSLEVEL) begin
                    regRdata <= {{(32-W){fsLevel_q[W-1]}}, fsLevel_q};
                end else if (regAddr == REG_STATUS) begin
                    regRdata <= {22'h000000, started_q, expired_q, 2'h0, act_q};
                end else if (regAddr == REG_TIMER) begin
                    regRdata <= timerLen_q;
                end else begin
                    for (int i = 0; i < N; i++) begin
                        if (regAddr == REG_RELAY_BASE + 8'(i) * REG_RELAY_STRIDE) begin
                            regRdata <= {25'h0000000, cfg_q[i]};
                        end else if (regAddr == REG_RELAY_BASE + 8'(i) * REG_RELAY_STRIDE
                                + 8'(RO_ON)) begin
                            regRdata <= {{(32-W){onSp_q[i][W-1]}}, onSp_q[i]};
                        end else if (regAddr == REG_RELAY_BASE + 8'(i) * REG_RELAY_STRIDE
                                + 8'(RO_OFF)) begin
                            regRdata <= {{(32-W){offSp_q[i][W-1]}}, offSp_q[i]};
                        end
                    end
                end
            end
        end
    end

    // checks
    property p_cable;
        @(posedge clk_sys) disable iff (rst)
        clkEn && measUpdate && cfg_q[3][3:0] == FN_CABLE && !navEntry |=> act_q[3] == $past(cableFault);
    endproperty
    a_cable: assert property (p_cable) else $error("cable alarm wrong");
    property p_hold;
        @(posedge clk_sys) disable iff (rst)
        !measUpdate && !navEntry |=> act_q == $past(act_q);
    endproperty
    a_hold: assert property (p_hold) else $error("relay changed without strobe");
    property p_nav;
        @(posedge clk_sys) disable iff (rst)
        clkEn && navEntry && cfg_q[1][3:0] == FN_PUMP |=> !act_q[1];
    endproperty
    a_nav: assert property (p_nav) else $error("pump not off on navigation");
    property p_start;
        @(posedge clk_sys) disable iff (rst)
        !started_q |=> relayCoil == '0;
    endproperty
    a_start: assert property (p_start) else $error("coil driven before first update");
    property p_echo;
        @(posedge clk_sys) disable iff (rst)
        clkEn && measUpdate && cfg_q[2][3:0] == FN_ECHO |=> act_q[2] == $past(expired_q);
    endproperty
    a_echo: assert property (p_echo) else $error("echo lost alarm wrong");
    property p_reset_timer;
        @(posedge clk_sys) disable iff (rst)
        clkEn && measUpdate && echoValid && !measError |=> !expired_q;
    endproperty
    a_reset_timer: assert property (p_reset_timer) else $error("timer not cleared");
    property p_inv;
        @(posedge clk_sys) disable iff (rst)
        clkEn && started_q && cfg_q[1][3:0] == FN_PUMP |=>
            relayCoil[1] == ($past(act_q[1]) ^ $past(cfg_q[1][CFG_INV_BIT]));
    endproperty
    a_inv: assert property (p_inv) else $error("pump coil sense wrong");
    property p_alarm;
        @(posedge clk_sys) disable iff (rst)
        clkEn && started_q && cfg_q[0][3:0] == FN_LEVEL |=>
            relayCoil[0] == (!$past(act_q[0]) ^ $past(cfg_q[0][CFG_INV_BIT]));
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm coil sense wrong");

endmodule : rsc_relay_ctrl

// ==== sim/rsc_plant_model.sv ====
// behavioural model of the sampler wired to one relay contact
`timescale 1ns/1ns
module rsc_plant_model #(
    parameter int IDX = 5
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // coil drives coming from the controller
    input wire logic [5:0] relayCoil,
    // what the sampler has seen
    output logic [15:0] closures,
    output logic [31:0] lastWidth
);
    logic coilPrev_q; // coil level one cycle ago
    logic [31:0] run_q; // length of the closure in progress

    // a sampler fires once per closing edge, so a stuck coil counts as one event only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            coilPrev_q <= 1'b0;
            closures <= 16'h0000;
            run_q <= 32'h0000_0000;
            lastWidth <= 32'h0000_0000;
        end else begin
            coilPrev_q <= relayCoil[IDX];
            if (relayCoil[IDX] && !coilPrev_q) begin // closing edge
                closures <= closures + 16'h0001;
            end
            if (relayCoil[IDX]) begin
                run_q <= run_q + 32'h0000_0001;
            end else if (coilPrev_q) begin // opening edge ends the closure
                lastWidth <= run_q;
                run_q <= 32'h0000_0000;
            end
        end
    end
endmodule : rsc_plant_model

// ==== sim/tb_top.sv ====
// self-checking bench for the relay setpoint controller
`timescale 1ns/1ns
module tb_top;
    import rsc_pkg::*;
    localparam int PULSE_SIM = 20; // shortened closure so the run stays short
    localparam logic [5:0] ALARM_MASK = 6'h0d; // plain alarm relays, coil opposes icon
    // clock, reset, enable
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    // register port
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0000_0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    // measurement front end
    logic measUpdate = 1'b0;
    logic signed [15:0] level1 = 16'sh0000;
    logic signed [15:0] level2 = 16'sh0000;
    logic signed [15:0] rate = 16'sh0000;
    logic signed [15:0] temperature = 16'sh0000;
    logic signed [15:0] span = 16'sh01f4; // band is ten counts
    logic measError = 1'b0;
    logic echoValid = 1'b1;
    logic cableFault = 1'b0;
    logic eventPulse = 1'b0;
    // relay outputs and sampler view
    logic [5:0] relayCoil;
    logic [5:0] relayIcon;
    logic [15:0] closures;
    logic [31:0] lastWidth;
    int fails = 0;
    int totalChecks = 0;

    always #10 clk_sys = ~clk_sys;

    rsc_relay_ctrl #(.PULSE_CYCLES(PULSE_SIM)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .measUpdate(measUpdate), .level1(level1), .level2(level2),
        .rate(rate), .temperature(temperature), .span(span), .measError(measError),
        .echoValid(echoValid), .cableFault(cableFault), .eventPulse(eventPulse),
        .relayCoil(relayCoil), .relayIcon(relayIcon)
    );

    rsc_plant_model #(.IDX(5)) u_plant (
        .clk_sys(clk_sys), .rst(rst), .relayCoil(relayCoil),
        .closures(closures), .lastWidth(lastWidth)
    );

    // one comparison, counted
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // verdict, reached from the main sequence or the watchdog
    task automatic results();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // single-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr

    // read, data stands only in the following cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 chk(regRdata, exp);
    endtask : rd

    // program one relay block; setpoints go out sign extended
    task automatic cfg(input int i, input logic [3:0] fn, input logic inv,
                       input logic signed [15:0] onV, input logic signed [15:0] offV);
        logic [7:0] b;
        b = REG_RELAY_BASE + REG_RELAY_STRIDE * 8'(i);
        wr(b + 8'(RO_CFG), {25'h0, inv, SRC_P1, fn});
        wr(b + 8'(RO_ON), {{16{onV[15]}}, onV});
        wr(b + 8'(RO_OFF), {{16{offV[15]}}, offV});
    endtask : cfg

    // present a measurement and strobe it in
    task automatic strobe(input logic signed [15:0] l, input logic signed [15:0] r,
                          input logic signed [15:0] t);
        @(posedge clk_sys);
        level1 <= l;
        rate <= r;
        temperature <= t;
        measUpdate <= 1'b1;
        @(posedge clk_sys);
        measUpdate <= 0;
    endtask : strobe

    // strobe, let the two-cycle path settle, compare icons and coils
    task automatic upd(input logic signed [15:0] l, input logic signed [15:0] r,
                       input logic signed [15:0] t, input logic [5:0] e);
        strobe(l, r, t);
        repeat (3) @(posedge clk_sys);
        #1 chk({26'h0, relayIcon}, {26'h0, e});
        chk({26'h0, relayCoil}, {26'h0, e ^ ALARM_MASK});
    endtask : upd

    // event on the sampler relay
    task automatic ev();
        @(posedge clk_sys);
        eventPulse <= 1'b1;
        @(posedge clk_sys);
        eventPulse <= 1'b0;
    endtask : ev

    // watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        results();
    end

    initial begin
        int n;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        // reset values and the register map edges
        rd(REG_TIMER, TIMER_RST);
        wr(8'hfc, 32'hffff_ffff);
        rd(8'hfc, 32'h0000_0000);
        cfg(0, FN_LEVEL, 1'b0, 100, 50);
        cfg(1, FN_PUMP, 1'b0, 100, 50);
        cfg(2, FN_INBND, 1'b0, 20, 60);
        cfg(3, FN_RATE, 1'b0, -30, -10);
        cfg(4, FN_TEMP, 1'b1, 10, 30);
        cfg(5, FN_PULSE, 1'b0, 1, 0);
        rd(8'h44, 32'hffff_ffe2);
        chk({26'h0, relayCoil}, 32'h0);
        $display("test registers done");
        // thresholds with hysteresis
        upd(80, 0, 20, 6'h00);
        upd(100, -30, 10, 6'h1b);
        upd(70, -20, 20, 6'h1b);
        @(posedge clk_sys);
        level1 <= -16'sd50;
        repeat (4) @(posedge clk_sys);
        #1 chk({26'h0, relayIcon}, 32'h1b);
        upd(40, -10, 30, 6'h04);
        upd(-50, 0, 20, 6'h00);
        cfg(2, FN_OUTBND, 1'b0, 20, 60);
        upd(-50, 0, 20, 6'h04);
        upd(40, 0, 20, 6'h00);
        $display("test setpoints done");
        // sampler closures, extra event during a closure ignored
        ev();
        n = 0;
        while (relayIcon[5] !== 1'b1 && n < 10) begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(n < 10), 32'h1);
        repeat (5) @(posedge clk_sys);
        ev();
        repeat (30) @(posedge clk_sys);
        chk({16'h0, closures}, 32'h1);
        chk(lastWidth, 32'(PULSE_SIM));
        ev();
        repeat (30) @(posedge clk_sys);
        chk({16'h0, closures}, 32'h2);
        $display("test sampler done");
        // loss of echo, cable fault and fail-safe modes
        cfg(2, FN_ECHO, 1'b0, 1, 0);
        cfg(3, FN_CABLE, 1'b0, 1, 0);
        wr(REG_TIMER, 32'h2);
        wr(REG_FSLEVEL, 32'h0000_00c8);
        wr(REG_CTRL, {30'h0, FS_HIGH});
        @(posedge clk_sys);
        measError <= 1'b1;
        echoValid <= 1'b0;
        cableFault <= 1'b1;
        // expiry is flagged on the strobe after the count reaches the length
        strobe(40, 0, 20);
        strobe(40, 0, 20);
        strobe(40, 0, 20);
        upd(40, 0, 20, 6'h0f);
        rd(REG_STATUS, 32'h0000_030f);
        wr(REG_CTRL, {30'h0, FS_HOLD});
        upd(40, 0, 20, 6'h0f);
        wr(REG_CTRL, {30'h0, FS_LOW});
        upd(40, 0, 20, 6'h0e);
        wr(REG_CTRL, {30'h0, FS_LOW} | 32'h10);
        repeat (4) @(posedge clk_sys);
        #1 chk({26'h0, relayIcon}, 32'h0c);
        @(posedge clk_sys);
        measError <= 1'b0;
        echoValid <= 1'b1;
        cableFault <= 1'b0;
        // the timer clears on this strobe, the echo alarm follows on the next
        strobe(40, 0, 20);
        upd(40, 0, 20, 6'h00);
        $display("test fail-safe done");
        // point three on relay 0: average, then difference of the two levels
        wr(REG_RELAY_BASE + 8'(RO_CFG), {25'h0, 1'b0, SRC_P3, FN_LEVEL});
        wr(REG_CTRL, 32'h0000_000c);
        @(posedge clk_sys);
        level2 <= 16'sd120;
        upd(80, 0, 20, 6'h01);
        wr(REG_CTRL, 32'h0000_0004);
        upd(80, 0, 20, 6'h00);
        $display("test point three done");
        results();
    end
endmodule : tb_top
